// ---- verification/pbseq_core_assertions.sv ----
// port-level checks for the sequencer core
`timescale 1ns/1ps
module pbseq_core_assertions #(
  parameter [31:0] DEBOUNCE_CYC = 32'h4,
  parameter [31:0] RECOVERY_CYC = 32'h8
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire main_button_n_i,
  input wire second_reset_button_n_i,
  input wire supply_hold_in_i,
  input wire supply_above_upper_i,
  input wire supply_above_lower_i,
  input wire power_enable_o,
  input wire host_reset_n_o,
  input wire interrupt_n_o,
  input wire button_state_out_n_o,
  input wire supply_low_out_n_o,
  input wire hold_pulldown_o,
  input wire reference_enable_o
);
  reg [31:0] bad_cnt;
  reg [31:0] rst_cnt;
  // saturate so a stuck input never wraps back into a false window
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bad_cnt <= 32'h0;
      rst_cnt <= 32'h0;
    end else begin
      if (!main_button_n_i && supply_above_upper_i)
        bad_cnt <= 32'h0;
      else if (bad_cnt != 32'hFF)
        bad_cnt <= bad_cnt + 32'h1;
      rst_cnt <= host_reset_n_o ? 32'h0 : rst_cnt + 32'h1;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  start_needs_press_a: assert property (bad_cnt >= DEBOUNCE_CYC + 4 |-> !$rose(power_enable_o))
    else $error("enable rose without a debounced press");
  start_reset_a: assert property ($rose(power_enable_o) |-> ##[0:2] !host_reset_n_o)
    else $error("no host reset after enable");
  reset_width_a: assert property ($rose(host_reset_n_o) |->
    rst_cnt + 1 >= RECOVERY_CYC && rst_cnt <= RECOVERY_CYC + 1)
    else $error("host reset pulse width wrong");
  reset_under_en_a: assert property (!host_reset_n_o |-> power_enable_o)
    else $error("host reset low while power is off");
  quiet_startup_a: assert property ($rose(power_enable_o) |-> interrupt_n_o[*8])
    else $error("interrupt low during power-up");
  int_width_a: assert property ($fell(interrupt_n_o) |=> !interrupt_n_o[*3])
    else $error("interrupt pulse too short");
  standby_int_a: assert property (!power_enable_o[*3] |-> interrupt_n_o)
    else $error("interrupt low in standby");
  ref_off_a: assert property (!power_enable_o[*2] |-> !reference_enable_o)
    else $error("reference on in standby");
  pulldown_on_a: assert property ($rose(power_enable_o) |-> ##[0:2] hold_pulldown_o)
    else $error("no pull-down during start-up");
  forced_off_a: assert property ((power_enable_o && reference_enable_o && host_reset_n_o
    && !hold_pulldown_o && !supply_hold_in_i)[*4] |-> ##[0:4] !power_enable_o)
    else $error("power kept with supply-hold low");
  supply_low_a: assert property ((power_enable_o && reference_enable_o && host_reset_n_o
    && !hold_pulldown_o && supply_hold_in_i && !supply_above_lower_i)[*4] |=> !interrupt_n_o)
    else $error("no interrupt on undervoltage");
endmodule

// ---- verification/pbseq_host_model.sv ----
// host processor model driving supply-hold
`timescale 1ns/1ps
module pbseq_host_model (
  input  wire core_clk_i,
  input  wire rst_i,
  input  wire host_reset_n_i,
  input  wire respond_i,
  output reg  supply_hold_o
);
  reg [1:0] init_cnt;
  // a silent host reads low through the pull-down
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      init_cnt      <= 2'h0;
      supply_hold_o <= 1'b0;
    end else if (!host_reset_n_i || !respond_i) begin
      init_cnt      <= 2'h0;
      supply_hold_o <= 1'b0;
    end else if (init_cnt != 2'h2) begin
      init_cnt <= init_cnt + 2'h1;
    end else begin
      supply_hold_o <= 1'b1;
    end
  end
endmodule

// ---- verification/test_push_button_power_sequencer.sv ----
// self-checking bench for the sequencer core
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %b got %b", nm, e, a); end end
module test_push_button_power_sequencer;
  reg     core_clk_i, rst_i, main_n, sr_n, upper, lower, respond, main_t_n;
  wire    en, rst_n, int_n, btn_n, low_n, pd, ref_en, hold;
  wire    en_t, rst_t, int_t, pd_t, hold_t;
  integer fail_count, checks_done, seed;
  integer rst_low = 0;
  integer int_low = 0;
  localparam integer REC_CYC = 8;
  localparam integer INT_CYC = 4;
  pbseq_core #(.DEBOUNCE_CYC(32'h4), .RECOVERY_CYC(32'h8), .BLANK_CYC(32'h40),
    .INT_MIN_CYC(32'h4), .EXTRA_CYC(32'h8)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .main_button_n_i(main_n), .second_reset_button_n_i(sr_n), .supply_hold_in_i(hold),
    .supply_above_upper_i(upper), .supply_above_lower_i(lower), .power_enable_o(en),
    .host_reset_n_o(rst_n), .interrupt_n_o(int_n), .button_state_out_n_o(btn_n),
    .supply_low_out_n_o(low_n), .hold_pulldown_o(pd), .reference_enable_o(ref_en));
  pbseq_host_model host (.core_clk_i(core_clk_i), .rst_i(rst_i), .host_reset_n_i(rst_n),
    .respond_i(respond), .supply_hold_o(hold));
  // second core: timed start-up, long push removes power
  pbseq_core #(.HOLD_VARIANT(0), .LONG_RESET(0), .DEBOUNCE_CYC(32'h4),
    .RECOVERY_CYC(32'h8), .BLANK_CYC(32'h40), .INT_MIN_CYC(32'h4), .EXTRA_CYC(32'h8))
    dut_t (.core_clk_i(core_clk_i), .rst_i(rst_i), .main_button_n_i(main_t_n),
    .second_reset_button_n_i(sr_n), .supply_hold_in_i(hold_t), .supply_above_upper_i(upper),
    .supply_above_lower_i(lower), .power_enable_o(en_t), .host_reset_n_o(rst_t),
    .interrupt_n_o(int_t), .button_state_out_n_o(), .supply_low_out_n_o(),
    .hold_pulldown_o(pd_t), .reference_enable_o());
  pbseq_host_model host_t (.core_clk_i(core_clk_i), .rst_i(rst_i), .host_reset_n_i(rst_t),
    .respond_i(respond), .supply_hold_o(hold_t));
  // pin-level width model: counts low samples of reset and interrupt
  always @(posedge core_clk_i) begin
    if (rst_n === 1'b0) begin
      rst_low <= rst_low + 1;
    end else if (rst_low != 0) begin
      `CHK("rst_n width", REC_CYC, rst_low)
      rst_low <= 0;
    end
    if (int_n === 1'b0) begin
      int_low <= int_low + 1;
    end else if (int_low != 0) begin
      `CHK("int_n width", 1'b1, int_low >= INT_CYC)
      int_low <= 0;
    end
  end
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  task step(input integer n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // w 0 watches enable, 1 host reset, 2 enable of the timed core
  task wait_for(input integer w, input logic v);
    integer k;
    begin
      k = 0;
      while (((w == 0) ? en : (w == 1) ? rst_n : en_t) !== v && k < 300) begin
        step(1);
        k = k + 1;
      end
      if (k == 300) begin
        fail_count++;
        $display("CHECK FAILED wait_for exp %b got timeout", v);
        tally_and_finish;
      end
    end
  endtask
  task power_up;
    begin
      main_n <= 1'b0;
      wait_for(0, 1'b1);
      step(20);
      main_n <= 1'b1;
      step(8);
    end
  endtask
  initial begin
    seed = 32'h413C1EF5;
    fail_count = 0;
    checks_done = 0;
    rst_i = 1'b1; main_n = 1'b1; sr_n = 1'b1; upper = 1'b1; lower = 1'b1; respond = 1'b1;
    main_t_n = 1'b1;
    step(4);
    rst_i <= 1'b0;
    `CHK("en", 1'b0, en)
    `CHK("rst_n", 1'b1, rst_n)
    `CHK("int_n", 1'b1, int_n)
    `CHK("pd", 1'b0, pd)
    main_n <= 1'b0;
    step(1 + {$random(seed)} % 2);
    main_n <= 1'b1;
    step(12);
    `CHK("en", 1'b0, en)
    upper <= 1'b0;
    main_n <= 1'b0;
    step(12);
    `CHK("en", 1'b0, en)
    upper <= 1'b1;
    wait_for(0, 1'b1);
    step(3);
    `CHK("rst_n", 1'b0, rst_n)
    step(20);
    main_n <= 1'b1;
    step(8);
    `CHK("en", 1'b1, en)
    `CHK("ref", 1'b1, ref_en)
    main_n <= 1'b0;
    step(10);
    `CHK("int_n", 1'b0, int_n)
    `CHK("btn_n", 1'b0, btn_n)
    main_n <= 1'b1;
    step(10);
    `CHK("int_n", 1'b1, int_n)
    `CHK("btn_n", 1'b1, btn_n)
    lower <= 1'b0;
    upper <= 1'b0;
    step(8);
    `CHK("int_n", 1'b0, int_n)
    `CHK("low_n", 1'b0, low_n)
    lower <= 1'b1;
    upper <= 1'b1;
    step(40);
    `CHK("en", 1'b1, en)
    main_n <= 1'b0;
    step(2);
    sr_n <= 1'b0;
    wait_for(1, 1'b0);
    main_n <= 1'b1;
    sr_n <= 1'b1;
    `CHK("en", 1'b1, en)
    step(100);
    `CHK("en", 1'b1, en)
    respond <= 1'b0;
    wait_for(0, 1'b0);
    step(2);
    `CHK("ref", 1'b0, ref_en)
    power_up;
    `CHK("en", 1'b0, en)
    main_n <= 1'b0;
    wait_for(0, 1'b1);
    step(90);
    `CHK("en", 1'b0, en)
    main_n <= 1'b1;
    respond <= 1'b1;
    step(10);
    power_up;
    lower <= 1'b0;
    upper <= 1'b0;
    wait_for(0, 1'b0);
    lower <= 1'b1;
    upper <= 1'b1;
    step(10);
    `CHK("en", 1'b0, en)
    // timed core, silent host: release ignored, power lost at blank end
    respond <= 1'b0;
    main_t_n <= 1'b0;
    wait_for(2, 1'b1);
    step(20);
    `CHK("int_t", 1'b1, int_t)
    `CHK("pd_t", 1'b1, pd_t)
    main_t_n <= 1'b1;
    step(8);
    `CHK("en_t", 1'b1, en_t)
    step(60);
    `CHK("en_t", 1'b0, en_t)
    // timed core, answering host: early release, power kept
    respond <= 1'b1;
    main_t_n <= 1'b0;
    wait_for(2, 1'b1);
    step(5);
    main_t_n <= 1'b1;
    step(80);
    `CHK("en_t", 1'b1, en_t)
    // long push on the power-off option
    main_t_n <= 1'b0;
    step(2);
    sr_n <= 1'b0;
    wait_for(2, 1'b0);
    `CHK("rst_t", 1'b1, rst_t)
    main_t_n <= 1'b1;
    sr_n <= 1'b1;
    step(4);
    tally_and_finish;
  end
endmodule
bind pbseq_core pbseq_core_assertions #(.DEBOUNCE_CYC(DEBOUNCE_CYC),
  .RECOVERY_CYC(RECOVERY_CYC)) chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .main_button_n_i(main_button_n_i), .second_reset_button_n_i(second_reset_button_n_i),
  .supply_hold_in_i(supply_hold_in_i), .supply_above_upper_i(supply_above_upper_i),
  .supply_above_lower_i(supply_above_lower_i), .power_enable_o(power_enable_o),
  .host_reset_n_o(host_reset_n_o), .interrupt_n_o(interrupt_n_o),
  .button_state_out_n_o(button_state_out_n_o), .supply_low_out_n_o(supply_low_out_n_o),
  .hold_pulldown_o(hold_pulldown_o), .reference_enable_o(reference_enable_o));

// ---- verilog/pbseq_core.v ----
// push-button power on/off sequencer core
// Behaviour
// - power-up needs button held, supply high
// - supply dip restarts the debounce count
// - debounce done: enable on, reset pulse
// - hold variant: hold before release/blank end
// - hold variant: low hold at release, off
// - hold variant: blank expiry samples hold
// - inputs and interrupt ignored until power-up
// - timed variant: sample hold at blank end
// - timed variant: ignore everything during blanking
// - interrupt stays high during power-up
// - button press gives minimum-width interrupt pulse
// - low supply-hold in normal operation, off
// - undervoltage drives interrupt low
// - persistent undervoltage removes power, back standby
// - supply recovery before timeout keeps power
// - both buttons long: reset or power off
// - after long-push reset, re-check hold later
// - second button watched for falling edges
// - enable off means standby, reference off
// - pull-down on supply-hold during start-up
// - button-state output debounced with minimum width
// - interrupt low while button held after debounce
`timescale 1ns/1ps
`include "pbseq_map.vh"
module pbseq_core #(
  parameter        HOLD_VARIANT  = 1,   // 1: hold-to-confirm, 0: timed
  parameter        LONG_RESET    = 1,   // 1: long push resets, 0: powers off
  parameter        EN_ACTIVE_LOW = 0,
  parameter [31:0] DEBOUNCE_CYC  = `PBSEQ_US_TO_CYC(`PBSEQ_DEBOUNCE_US),
  parameter [31:0] RECOVERY_CYC  = `PBSEQ_US_TO_CYC(`PBSEQ_RECOVERY_US),
  parameter [31:0] BLANK_CYC     = `PBSEQ_US_TO_CYC(`PBSEQ_BLANK_US),
  parameter [31:0] INT_MIN_CYC   = `PBSEQ_US_TO_CYC(`PBSEQ_INT_MIN_US),
  parameter [31:0] EXTRA_CYC     = `PBSEQ_US_TO_CYC(`PBSEQ_EXTRA_US)
) (
  input  wire core_clk_i,
  input  wire rst_i,
  input  wire main_button_n_i,
  input  wire second_reset_button_n_i,
  input  wire supply_hold_in_i,
  input  wire supply_above_upper_i,
  input  wire supply_above_lower_i,
  output reg  power_enable_o,
  output reg  host_reset_n_o,
  output reg  interrupt_n_o,
  output reg  button_state_out_n_o,
  output reg  supply_low_out_n_o,
  output reg  hold_pulldown_o,
  output reg  reference_enable_o
);
  localparam ST_STANDBY    = `PBSEQ_ST_STANDBY;
  localparam ST_DEBOUNCE   = `PBSEQ_ST_DEBOUNCE;
  localparam ST_STARTUP    = `PBSEQ_ST_STARTUP;
  localparam ST_RUN        = `PBSEQ_ST_RUN;
  localparam ST_LONG_RESET = `PBSEQ_ST_LONG_RESET;
  localparam [31:0] LONG_CYC = DEBOUNCE_CYC + INT_MIN_CYC + EXTRA_CYC;
  localparam [31:0] ONE      = 32'h00000001;

  wire main_n;
  wire second_n;
  wire hold;
  wire up_ok;
  wire lo_ok;

  pbseq_sync #(.RST_VAL(1'b1)) u_sync_main (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    (main_button_n_i),
    .sync_o     (main_n)
  );
  pbseq_sync #(.RST_VAL(1'b1)) u_sync_second (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    (second_reset_button_n_i),
    .sync_o     (second_n)
  );
  pbseq_sync #(.RST_VAL(1'b0)) u_sync_hold (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    (supply_hold_in_i),
    .sync_o     (hold)
  );
  pbseq_sync #(.RST_VAL(1'b0)) u_sync_up (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    (supply_above_upper_i),
    .sync_o     (up_ok)
  );
  pbseq_sync #(.RST_VAL(1'b0)) u_sync_lo (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    (supply_above_lower_i),
    .sync_o     (lo_ok)
  );

  reg [2:0]  state;
  reg [31:0] seq_cnt;     // debounce / blanking timer
  reg [31:0] rst_cnt;     // reset recovery timer
  reg [31:0] press_cnt;   // main button hold time
  reg [31:0] pulse_cnt;   // minimum width of interrupt / button-state
  reg [31:0] uv_cnt;      // undervoltage persistence
  reg [31:0] long_cnt;    // both-button hold time
  reg        main_d;
  reg        second_d;
  reg        second_armed;
  reg        pressed;
  reg        uv;
  reg        en;

  wire main_fall   = main_d & ~main_n;
  wire second_fall = second_d & ~second_n;
  wire press_done  = pressed && (press_cnt >= DEBOUNCE_CYC);
  wire pulse_busy  = (pulse_cnt != 32'h00000000);

  always @* begin
    power_enable_o = (EN_ACTIVE_LOW != 0) ? ~en : en;
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state                <= ST_STANDBY;
      seq_cnt              <= 32'h00000000;
      rst_cnt              <= 32'h00000000;
      press_cnt            <= 32'h00000000;
      pulse_cnt            <= 32'h00000000;
      uv_cnt               <= 32'h00000000;
      long_cnt             <= 32'h00000000;
      main_d               <= 1'b1;
      second_d             <= 1'b1;
      second_armed         <= 1'b0;
      pressed              <= 1'b0;
      uv                   <= 1'b0;
      en                   <= 1'b0;
      host_reset_n_o       <= 1'b1;
      interrupt_n_o        <= 1'b1;
      button_state_out_n_o <= 1'b1;
      supply_low_out_n_o   <= 1'b1;
      hold_pulldown_o      <= 1'b0;
      reference_enable_o   <= 1'b0;
    end else begin
      main_d   <= main_n;
      second_d <= second_n;
      if (rst_cnt != 32'h00000000) begin
        rst_cnt <= rst_cnt - ONE;
      end
      host_reset_n_o <= (rst_cnt <= ONE);
      reference_enable_o <= en && (rst_cnt == 32'h00000000);
      case (state)
        ST_STANDBY: begin
          en                   <= 1'b0;
          interrupt_n_o        <= 1'b1;
          button_state_out_n_o <= 1'b1;
          supply_low_out_n_o   <= 1'b1;
          hold_pulldown_o      <= 1'b0;
          seq_cnt              <= 32'h00000000;
          if (main_fall) begin
            state <= ST_DEBOUNCE;
          end
        end
        ST_DEBOUNCE: begin
          supply_low_out_n_o <= up_ok;
          if (main_n) begin
            state <= ST_STANDBY;
          end else if (!up_ok) begin
            seq_cnt <= 32'h00000000;
          end else if (seq_cnt + ONE >= DEBOUNCE_CYC) begin
            en              <= 1'b1;
            rst_cnt         <= RECOVERY_CYC;
            host_reset_n_o  <= 1'b0;
            hold_pulldown_o <= 1'b1;
            seq_cnt         <= 32'h00000000;
            state           <= ST_STARTUP;
          end else begin
            seq_cnt <= seq_cnt + ONE;
          end
        end
        ST_STARTUP: begin
          // blanking: second button, interrupt and undervoltage ignored; main release acts only in the hold variant
          interrupt_n_o <= 1'b1;
          seq_cnt       <= seq_cnt + ONE;
          if (seq_cnt + ONE >= BLANK_CYC) begin
            if (hold) begin
              state <= ST_RUN;
            end else begin
              state <= ST_STANDBY;
            end
            hold_pulldown_o <= 1'b0;
            second_armed    <= 1'b0;
            pressed         <= 1'b0;
            uv_cnt          <= 32'h00000000;
            long_cnt        <= 32'h00000000;
          end else if ((HOLD_VARIANT != 0) && main_n && (rst_cnt == 32'h00000000)) begin
            // hold variant: button release ends the start-up window
            if (hold) begin
              state <= ST_RUN;
            end else begin
              en    <= 1'b0;
              state <= ST_STANDBY;
            end
            hold_pulldown_o <= 1'b0;
            second_armed    <= 1'b0;
            pressed         <= 1'b0;
            uv_cnt          <= 32'h00000000;
            long_cnt        <= 32'h00000000;
          end
          if ((seq_cnt + ONE >= BLANK_CYC) && !hold) begin
            en <= 1'b0;
          end
        end
        ST_RUN: begin
          hold_pulldown_o <= 1'b0;
          // button press tracking, only a fresh falling edge starts a press
          if (main_fall && !pulse_busy) begin
            pressed   <= 1'b1;
            press_cnt <= 32'h00000000;
          end else if (main_n) begin
            pressed <= 1'b0;
          end else if (pressed && (press_cnt != LONG_CYC)) begin
            press_cnt <= press_cnt + ONE;
          end
          if (pressed && !main_n && (press_cnt + ONE == DEBOUNCE_CYC)) begin
            pulse_cnt <= INT_MIN_CYC;
          end else if (pulse_busy) begin
            pulse_cnt <= pulse_cnt - ONE;
          end
          // undervoltage masks the held-button term of the button state pin, not the pulse
          button_state_out_n_o <= ~((press_done && !main_n && !uv) || pulse_busy);
          uv                   <= ~lo_ok | (uv & ~up_ok);
          supply_low_out_n_o   <= ~uv;
          interrupt_n_o <= ~(uv || pulse_busy || (press_done && !main_n));
          if (uv) begin
            uv_cnt <= uv_cnt + ONE;
          end else begin
            uv_cnt <= 32'h00000000;
          end
          if (second_fall) begin
            second_armed <= 1'b1;
          end else if (second_n) begin
            second_armed <= 1'b0;
          end
          if (second_armed && !second_n && press_done) begin
            long_cnt <= long_cnt + ONE;
          end else begin
            long_cnt <= 32'h00000000;
          end
          if (!hold) begin
            en    <= 1'b0;
            state <= ST_STANDBY;
          end else if (uv && (uv_cnt + ONE >= LONG_CYC)) begin
            en    <= 1'b0;
            state <= ST_STANDBY;
          end else if (long_cnt + ONE >= LONG_CYC) begin
            long_cnt     <= 32'h00000000;
            second_armed <= 1'b0;
            pressed      <= 1'b0;
            if (LONG_RESET != 0) begin
              rst_cnt         <= RECOVERY_CYC;
              host_reset_n_o  <= 1'b0;
              hold_pulldown_o <= 1'b1;
              seq_cnt         <= 32'h00000000;
              state           <= ST_LONG_RESET;
            end else begin
              en    <= 1'b0;
              state <= ST_STANDBY;
            end
          end
        end
        ST_LONG_RESET: begin
          interrupt_n_o <= 1'b1;
          seq_cnt       <= seq_cnt + ONE;
          if (seq_cnt + ONE >= BLANK_CYC) begin
            hold_pulldown_o <= 1'b0;
            uv_cnt          <= 32'h00000000;
            if (hold) begin
              state <= ST_RUN;
            end else begin
              en    <= 1'b0;
              state <= ST_STANDBY;
            end
          end
        end
        default: begin
          en    <= 1'b0;
          state <= ST_STANDBY;
        end
      endcase
    end
  end
endmodule

// ---- verilog/pbseq_map.vh ----
// timing constants and encodings for the push-button power sequencer
`ifndef PBSEQ_MAP_VH
`define PBSEQ_MAP_VH
`define PBSEQ_CLK_HZ          50000000
`define PBSEQ_DEBOUNCE_US     30000
`define PBSEQ_RECOVERY_US     200000
`define PBSEQ_BLANK_US        10000000
`define PBSEQ_INT_MIN_US      30000
`define PBSEQ_EXTRA_US        1000000
`define PBSEQ_US_TO_CYC(t)    (((t) * 50) )
`define PBSEQ_CNT_W           32
`define PBSEQ_ST_STANDBY      3'h0
`define PBSEQ_ST_DEBOUNCE     3'h1
`define PBSEQ_ST_STARTUP      3'h2
`define PBSEQ_ST_RUN          3'h3
`define PBSEQ_ST_LONG_RESET   3'h4
`endif

// ---- verilog/pbseq_sync.v ----
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pbseq_sync #(
  parameter RST_VAL = 1'b1
) (
  input  wire core_clk_i,
  input  wire rst_i,
  input  wire async_i,
  output reg  sync_o
);
  reg meta;

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta   <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule
